/* File: servo_status_defs.svh */
// Constant definitions for the servo status output block.
`ifndef SERVO_STATUS_DEFS_SVH
`define SERVO_STATUS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ALARMS 8'h08
`define REG_IRQ_STAT 8'h0c
`define REG_IRQ_MASK 8'h10
`define REG_TEACH_LIM 8'h14
`define REG_OUT_FUNC0 8'h20
`define REG_OUT_FUNC_LAST 8'h30

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_WPROT 0
`define CTRL_SEQ_SEL 1
`define CTRL_EDIT_ASGN 2
`define CTRL_ALM_CLR 3
`define ST_READY 0
`define ST_EDIT 1
`define ST_DATA_ERR 2
`define ST_ADDR_ERR 3
`define ST_CODE_LO 4
`define ST_CODE_HI 8
`define EV_READY_LOST 0
`define EV_ALARM 1
`define EV_ADDR_ERR 2
`define EV_DATA_ERR 3

// ----------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------
`define NUM_ALARMS 28
`define NUM_TERMS 5
`define NUM_EVENTS 4
`define NUM_PINS 40
`define POS_MAX 4'hf
`define TEACH_LIM_RST 16'hffff
`define OUT_FUNC_RST 8'h00

// ----------------------------------------------------------------
// Five-bit alarm codes
// ----------------------------------------------------------------
`define CODE_NONE 5'h00
`define CODE_OVERLOAD 5'h01
`define CODE_AMP_HEAT 5'h03
`define CODE_RESISTOR 5'h04
`define CODE_DEV_OVF 5'h05
`define CODE_OVERCUR 5'h06
`define CODE_OVERSPD 5'h07
`define CODE_OVERVOLT 5'h08
`define CODE_UNDERVOLT 5'h09
`define CODE_ENC_TRBL 5'h0a
`define CODE_INIT_ERR 5'h0b
`define CODE_CIRCUIT 5'h0c
`define CODE_MEMORY 5'h0d
`define CODE_FUSE 5'h0f
`define CODE_ENC_COMM 5'h10
`define CODE_MOTOR_CMB 5'h11
`define CODE_TRANS_HEAT 5'h12
`define CODE_CTRL_IN 5'h13
`define CODE_ENC_HEAT 5'h14
`define CODE_ABS_LOST 5'h15
`define CODE_MULTI_OVF 5'h16

`endif

/* File: servo_status_pkg.sv */
// Types shared by the servo status output block.
package servo_status_pkg;

  // Output terminal function codes selectable per terminal.
  typedef enum logic [7:0] {
    FN_NONE = 8'h00,
    FN_ALARM_DET = 8'h10,
    FN_READY = 8'h1c,
    FN_EDIT_RESP = 8'h1d,
    FN_DATA_ERR = 8'h1e,
    FN_ADDR_ERR = 8'h1f,
    FN_ALM_B0 = 8'h20,
    FN_ALM_B1 = 8'h21,
    FN_ALM_B2 = 8'h22,
    FN_ALM_B3 = 8'h23,
    FN_ALM_B4 = 8'h24
  } out_func_t;

  typedef enum logic [1:0] {
    AHB_IDLE = 2'b00,
    AHB_BUSY = 2'b01,
    AHB_NONSEQ = 2'b10,
    AHB_SEQ = 2'b11
  } htrans_t;

endpackage : servo_status_pkg

/* File: servo_status_out.sv */
// Servo amplifier status outputs: ready, edit response, error flags, alarm code.
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`include "servo_status_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module servo_status_out (
  input wire logic hclk, // 25 MHz system clock
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [7:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write not read
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready, never stalls
  output logic hresp, // always OKAY
  output logic [31:0] hrdata, // read data
  input wire logic forced_stop_in, // forced stop input, on means run allowed
  input wire logic free_run_in, // free-run input
  input wire logic cpu_healthy_in, // processor watchdog healthy
  input wire logic main_power_phase_a, // main power phase present
  input wire logic main_power_phase_b, // main power phase present
  input wire logic main_power_phase_c, // main power phase present
  input wire logic edit_permit_in, // edit permission input
  input wire logic start_position_in, // start positioning input
  input wire logic [3:0] position_select_in, // position select bits 3..0
  input wire logic [27:0] alarm_in, // alarm detail levels, index 0 ranks first
  input wire logic teach_strobe, // one-cycle teaching write, same clock
  input wire logic [3:0] teach_addr, // teaching positioning data number
  input wire logic [15:0] teach_data, // teaching data value
  output logic [4:0] out_term, // sequence output terminals
  output logic servo_ready, // servo control ready
  output logic edit_response, // edit permission response
  output logic param_write_allow, // parameter changes accepted
  output logic data_error, // data error flag
  output logic address_error, // address error flag
  output logic alarm_detect, // any alarm latched
  output logic alarm_code_bit0, // alarm code bit 0
  output logic alarm_code_bit1, // alarm code bit 1
  output logic alarm_code_bit2, // alarm code bit 2
  output logic alarm_code_bit3, // alarm code bit 3
  output logic alarm_code_bit4, // alarm code bit 4, most significant
  output logic irq // level interrupt
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // A change is taken only once the second and third stages agree,
  // which rejects a one-cycle glitch at the cost of one extra cycle.
  logic [`NUM_PINS-1:0] pin_raw;
  logic [`NUM_PINS-1:0] sync1_q;
  logic [`NUM_PINS-1:0] sync2_q;
  logic [`NUM_PINS-1:0] sync3_q;
  logic [`NUM_PINS-1:0] pin_q;

  assign pin_raw = {alarm_in, position_select_in, start_position_in, edit_permit_in,
                    main_power_phase_c, main_power_phase_b, main_power_phase_a,
                    cpu_healthy_in, free_run_in, forced_stop_in};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < `NUM_PINS; gp = gp + 1) begin : g_pin
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_q[gp] <= 1'b0;
        end else if (sync2_q[gp] == sync3_q[gp]) begin
          pin_q[gp] <= sync3_q[gp];
        end
      end
    end
  endgenerate

  logic stop_ok;
  logic free_run;
  logic cpu_ok;
  logic power_ok;
  logic edit_permit;
  logic start_pos;
  logic [3:0] pos_sel;
  logic [`NUM_ALARMS-1:0] alarm_lvl;

  assign stop_ok = pin_q[0];
  assign free_run = pin_q[1];
  assign cpu_ok = pin_q[2];
  assign power_ok = pin_q[3] & pin_q[4] & pin_q[5];
  assign edit_permit = pin_q[6];
  assign start_pos = pin_q[7];
  assign pos_sel = pin_q[11:8];
  assign alarm_lvl = pin_q[`NUM_PINS-1:12];

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic rd_take;
  logic wr_take;
  logic [31:0] rd_mux;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rd_take = hsel & hready & htrans[1] & ~hwrite;
  assign wr_take = hsel & hready & htrans[1] & hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= wr_take;
      wr_addr_q <= haddr;
    end
  end

  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic wr_lim;

  assign wr_ctrl = wr_pend_q && wr_addr_q == `REG_CTRL;
  assign wr_stat = wr_pend_q && wr_addr_q == `REG_IRQ_STAT;
  assign wr_mask = wr_pend_q && wr_addr_q == `REG_IRQ_MASK;
  assign wr_lim = wr_pend_q && wr_addr_q == `REG_TEACH_LIM;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic write_protect_q;
  logic seq_start_sel_q;
  logic edit_assigned_q;
  logic [15:0] teach_lim_q;
  logic alarm_clear;
  logic [7:0] out_func_q [`NUM_TERMS];

  assign alarm_clear = wr_ctrl & hwdata[`CTRL_ALM_CLR];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_protect_q <= 1'b0;
      seq_start_sel_q <= 1'b0;
      edit_assigned_q <= 1'b0;
    end else if (wr_ctrl) begin
      write_protect_q <= hwdata[`CTRL_WPROT];
      seq_start_sel_q <= hwdata[`CTRL_SEQ_SEL];
      edit_assigned_q <= hwdata[`CTRL_EDIT_ASGN];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      teach_lim_q <= `TEACH_LIM_RST;
    end else if (wr_lim) begin
      teach_lim_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `NUM_TERMS; i++) begin
        out_func_q[i] <= `OUT_FUNC_RST;
      end
    end else begin
      for (int i = 0; i < `NUM_TERMS; i++) begin
        if (wr_pend_q && wr_addr_q == 8'(`REG_OUT_FUNC0 + 4 * i)) begin
          out_func_q[i] <= hwdata[7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Alarm latch and priority encoder
  // ----------------------------------------------------------------
  // Alarms latch so a brief fault is not lost; a new alarm level in the
  // clearing cycle stays latched.
  logic [`NUM_ALARMS-1:0] alarm_q;
  logic [4:0] code_d;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_q <= '0;
    end else begin
      alarm_q <= (alarm_clear ? '0 : alarm_q) | alarm_lvl;
    end
  end

  // Index order is the ranking; every index 0 to 27 has an entry.
  function automatic logic [4:0] code_of(input int idx);
    case (idx)
      0, 1: code_of = `CODE_OVERCUR;
      2: code_of = `CODE_OVERSPD;
      3: code_of = `CODE_OVERVOLT;
      4, 5: code_of = `CODE_ENC_TRBL;
      6: code_of = `CODE_CIRCUIT;
      7: code_of = `CODE_MEMORY;
      8: code_of = `CODE_FUSE;
      9: code_of = `CODE_MOTOR_CMB;
      10: code_of = `CODE_TRANS_HEAT;
      11: code_of = `CODE_ENC_COMM;
      12: code_of = `CODE_CTRL_IN;
      13, 14: code_of = `CODE_OVERLOAD;
      15: code_of = `CODE_RESISTOR;
      16: code_of = `CODE_UNDERVOLT;
      17, 18, 19: code_of = `CODE_RESISTOR;
      20: code_of = `CODE_DEV_OVF;
      21: code_of = `CODE_AMP_HEAT;
      22: code_of = `CODE_ENC_HEAT;
      23, 24, 25: code_of = `CODE_ABS_LOST;
      26: code_of = `CODE_MULTI_OVF;
      27: code_of = `CODE_INIT_ERR;
      default: code_of = `CODE_NONE;
    endcase
  endfunction : code_of

  always_comb begin
    code_d = `CODE_NONE;
    for (int i = `NUM_ALARMS - 1; i >= 0; i--) begin
      if (alarm_q[i]) begin
        code_d = code_of(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  logic ready_q;
  logic edit_q;
  logic data_err_q;
  logic addr_err_q;
  logic alarm_det_q;
  logic [4:0] code_q;
  logic start_prev_q;
  logic start_rise;

  assign start_rise = start_pos & ~start_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b0;
      edit_q <= 1'b0;
      alarm_det_q <= 1'b0;
      code_q <= `CODE_NONE;
      start_prev_q <= 1'b0;
    end else begin
      alarm_det_q <= |alarm_q;
      ready_q <= stop_ok & ~free_run & ~(|alarm_q) & cpu_ok & power_ok;
      edit_q <= ~write_protect_q & (~edit_assigned_q | edit_permit);
      code_q <= code_d;
      start_prev_q <= start_pos;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_err_q <= 1'b0;
    end else if (start_rise) begin
      if (pos_sel == 4'h0) begin
        if (!seq_start_sel_q) begin
          addr_err_q <= 1'b1;
        end
      end else begin
        addr_err_q <= 1'b0;
      end
    end
  end

  // Number 0 is not a storable positioning number, so it counts as out of range.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_err_q <= 1'b0;
    end else if (teach_strobe) begin
      data_err_q <= teach_addr == 4'h0 || teach_addr > `POS_MAX || teach_data > teach_lim_q;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [`NUM_EVENTS-1:0] irq_stat_q;
  logic [`NUM_EVENTS-1:0] irq_mask_q;
  logic [`NUM_EVENTS-1:0] ev;
  logic ready_prev_q;
  logic alm_prev_q;
  logic aerr_prev_q;
  logic derr_prev_q;

  assign ev[`EV_READY_LOST] = ready_prev_q & ~ready_q;
  assign ev[`EV_ALARM] = alarm_det_q & ~alm_prev_q;
  assign ev[`EV_ADDR_ERR] = addr_err_q & ~aerr_prev_q;
  assign ev[`EV_DATA_ERR] = data_err_q & ~derr_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_prev_q <= 1'b0;
      alm_prev_q <= 1'b0;
      aerr_prev_q <= 1'b0;
      derr_prev_q <= 1'b0;
    end else begin
      ready_prev_q <= ready_q;
      alm_prev_q <= alarm_det_q;
      aerr_prev_q <= addr_err_q;
      derr_prev_q <= data_err_q;
    end
  end

  // A new event wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? hwdata[`NUM_EVENTS-1:0] : '0)) | ev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_q <= '0;
    end else if (wr_mask) begin
      irq_mask_q <= hwdata[`NUM_EVENTS-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------
  // Output terminal routing
  // ----------------------------------------------------------------
  genvar gt;
  generate
    for (gt = 0; gt < `NUM_TERMS; gt = gt + 1) begin : g_term
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          out_term[gt] <= 1'b0;
        end else begin
          case (servo_status_pkg::out_func_t'(out_func_q[gt]))
            servo_status_pkg::FN_ALARM_DET: out_term[gt] <= alarm_det_q;
            servo_status_pkg::FN_READY: out_term[gt] <= ready_q;
            servo_status_pkg::FN_EDIT_RESP: out_term[gt] <= edit_q;
            servo_status_pkg::FN_DATA_ERR: out_term[gt] <= data_err_q;
            servo_status_pkg::FN_ADDR_ERR: out_term[gt] <= addr_err_q;
            servo_status_pkg::FN_ALM_B0: out_term[gt] <= code_q[0];
            servo_status_pkg::FN_ALM_B1: out_term[gt] <= code_q[1];
            servo_status_pkg::FN_ALM_B2: out_term[gt] <= code_q[2];
            servo_status_pkg::FN_ALM_B3: out_term[gt] <= code_q[3];
            servo_status_pkg::FN_ALM_B4: out_term[gt] <= code_q[4];
            default: out_term[gt] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  assign servo_ready = ready_q;
  assign edit_response = edit_q;
  assign param_write_allow = edit_q;
  assign data_error = data_err_q;
  assign address_error = addr_err_q;
  assign alarm_detect = alarm_det_q;
  assign alarm_code_bit0 = code_q[0];
  assign alarm_code_bit1 = code_q[1];
  assign alarm_code_bit2 = code_q[2];
  assign alarm_code_bit3 = code_q[3];
  assign alarm_code_bit4 = code_q[4];

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    case (haddr)
      `REG_CTRL: begin
        rd_mux[`CTRL_WPROT] = write_protect_q;
        rd_mux[`CTRL_SEQ_SEL] = seq_start_sel_q;
        rd_mux[`CTRL_EDIT_ASGN] = edit_assigned_q;
      end
      `REG_STATUS: begin
        rd_mux[`ST_READY] = ready_q;
        rd_mux[`ST_EDIT] = edit_q;
        rd_mux[`ST_DATA_ERR] = data_err_q;
        rd_mux[`ST_ADDR_ERR] = addr_err_q;
        rd_mux[`ST_CODE_HI:`ST_CODE_LO] = code_q;
      end
      `REG_ALARMS: rd_mux[`NUM_ALARMS-1:0] = alarm_q;
      `REG_IRQ_STAT: rd_mux[`NUM_EVENTS-1:0] = irq_stat_q;
      `REG_IRQ_MASK: rd_mux[`NUM_EVENTS-1:0] = irq_mask_q;
      `REG_TEACH_LIM: rd_mux[15:0] = teach_lim_q;
      default: begin
        for (int i = 0; i < `NUM_TERMS; i++) begin
          if (haddr == 8'(`REG_OUT_FUNC0 + 4 * i)) begin
            rd_mux[7:0] = out_func_q[i];
          end
        end
      end
    endcase
  end

  // Read data is captured in the address phase so it stands from a flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_take) begin
      hrdata <= rd_mux;
    end
  end

endmodule : servo_status_out

`default_nettype wire

/* File: servo_status_out_chk.sv */
// Port assertions for the servo status output block.
`timescale 1ns/1ns
`default_nettype none

module servo_status_out_chk (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, low
  input wire logic forced_stop_in, // forced stop
  input wire logic free_run_in, // free-run
  input wire logic start_position_in, // start
  input wire logic [3:0] position_select_in, // number
  input wire logic [27:0] alarm_in, // alarms
  input wire logic teach_strobe, // teach
  input wire logic [3:0] teach_addr, // teach number
  input wire logic servo_ready, // ready
  input wire logic data_error, // data error
  input wire logic address_error, // address error
  input wire logic alarm_detect, // alarm
  input wire logic alarm_code_bit0, // code
  input wire logic alarm_code_bit1, // code
  input wire logic alarm_code_bit2, // code
  input wire logic alarm_code_bit3, // code
  input wire logic alarm_code_bit4 // code
);
  logic [4:0] code;
  assign code = {alarm_code_bit4, alarm_code_bit3, alarm_code_bit2, alarm_code_bit1, alarm_code_bit0};
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Inputs pass a synchroniser, so each cause is held eight cycles before its effect is due.
  sequence s_valid_start;
    $rose(start_position_in) ##0 (start_position_in && position_select_in != 4'h0)[*8];
  endsequence
  sequence s_stop_cause;
    (!forced_stop_in || free_run_in)[*8];
  endsequence

  property p_ready_stop; s_stop_cause |-> !servo_ready; endproperty
  a_ready_stop: assert property (p_ready_stop) else $error("ready while stopped");
  property p_alarm_ready; alarm_detect |-> ##[0:1] !servo_ready; endproperty
  a_alarm_ready: assert property (p_alarm_ready) else $error("ready during alarm");
  property p_alarm_code; alarm_detect [*2] |-> code != 5'h00; endproperty
  a_alarm_code: assert property (p_alarm_code) else $error("alarm without code");
  property p_code_none; !alarm_detect [*2] |-> code == 5'h00; endproperty
  a_code_none: assert property (p_code_none) else $error("code without alarm");
  property p_rank_first; alarm_in[0] [*8] |-> code == 5'h06; endproperty
  a_rank_first: assert property (p_rank_first) else $error("top alarm not shown");
  property p_addr_clear; s_valid_start |-> !address_error; endproperty
  a_addr_clear: assert property (p_addr_clear) else $error("address error kept");
  property p_data_err; teach_strobe && teach_addr == 4'h0 |-> ##[1:3] data_error; endproperty
  a_data_err: assert property (p_data_err) else $error("bad teach not flagged");
  property p_reset_quiet; $rose(hresetn) |-> !servo_ready && !alarm_detect && code == 5'h00; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
endmodule : servo_status_out_chk

`default_nettype wire

/* File: servo_host_model.sv */
// Host controller model: drives teaching and start inputs, samples the terminals.
`timescale 1ns/1ns
`default_nettype none

module servo_host_model (
  input wire logic hclk, // clock
  input wire logic [4:0] out_term, // device terminals
  output logic teach_strobe, // teaching write
  output logic [3:0] teach_addr, // teaching number
  output logic [15:0] teach_data, // teaching value
  output logic start_position_in, // start
  output logic [3:0] position_select_in, // positioning number
  output logic [4:0] term_seen // last terminal sample
);
  initial begin
    teach_strobe = 1'b0;
    teach_addr = 4'h0;
    teach_data = 16'h0000;
    start_position_in = 1'b0;
    position_select_in = 4'h0;
  end

  always_ff @(posedge hclk) begin
    term_seen <= out_term;
  end

  // Outside the strobe the qualifiers carry junk, so nothing may rely on stale values.
  task automatic teach(input logic [3:0] a, input logic [15:0] d);
    teach_strobe <= 1'b1;
    teach_addr <= a;
    teach_data <= d;
    @(posedge hclk);
    teach_strobe <= 1'b0;
    teach_addr <= ~a;
    teach_data <= ~d;
  endtask : teach

  task automatic start(input logic [3:0] sel);
    position_select_in <= sel;
    repeat (8) @(posedge hclk);
    start_position_in <= 1'b1;
    repeat (12) @(posedge hclk);
    start_position_in <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask : start
endmodule : servo_host_model

`default_nettype wire

/* File: test_servo_status_out.sv */
// Self-checking bench for the servo status output block.
`timescale 1ns/1ns
`default_nettype none

module test_servo_status_out;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, fstop, frun, cpu, permit, irq;
  logic teach_strobe, start_position_in, servo_ready, edit_response, param_write_allow;
  logic data_error, address_error, alarm_detect, b0, b1, b2, b3, b4;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic [2:0] pwr;
  logic [27:0] alarms;
  logic [3:0] teach_addr, position_select_in;
  logic [15:0] teach_data;
  logic [4:0] out_term, term_seen, code;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [7:0] fa [5] = '{8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h10};
  logic [3:0] et [6] = '{4'b0001, 4'b1000, 4'b1101, 4'b0010, 4'b1010, 4'b1110};
  logic [20:0] tt [4] = '{{1'b1, 4'h0, 16'h0005}, {1'b0, 4'h3, 16'h0005}, {1'b1, 4'h3, 16'h0101}, {1'b0, 4'h3, 16'h0100}};
  logic [5:0] at [5] = '{6'b000001, 6'b100001, 6'b001010, 6'b000001, 6'b011110};
  logic [27:0] av [12] = '{28'h2000, 28'h1, 28'h100, 28'h800000, 28'h1000000, 28'h2000000, 28'h4000000,
    28'h1000, 28'h4000100, 28'h2101, 28'h18000, 28'h8400000};
  logic [4:0] ac [12] = '{5'h01, 5'h06, 5'h0f, 5'h15, 5'h15, 5'h15, 5'h16, 5'h13, 5'h0f, 5'h06, 5'h04, 5'h14};
  assign code = {b4, b3, b2, b1, b0};

  servo_status_out servo_status_out_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .forced_stop_in(fstop), .free_run_in(frun),
    .cpu_healthy_in(cpu), .main_power_phase_a(pwr[0]), .main_power_phase_b(pwr[1]),
    .main_power_phase_c(pwr[2]), .edit_permit_in(permit), .start_position_in(start_position_in),
    .position_select_in(position_select_in), .alarm_in(alarms), .teach_strobe(teach_strobe),
    .teach_addr(teach_addr), .teach_data(teach_data), .out_term(out_term), .servo_ready(servo_ready),
    .edit_response(edit_response), .param_write_allow(param_write_allow), .data_error(data_error),
    .address_error(address_error), .alarm_detect(alarm_detect), .alarm_code_bit0(b0),
    .alarm_code_bit1(b1), .alarm_code_bit2(b2), .alarm_code_bit3(b3), .alarm_code_bit4(b4), .irq(irq));

  servo_host_model servo_host_model_inst (.hclk(hclk), .out_term(out_term), .teach_strobe(teach_strobe),
    .teach_addr(teach_addr), .teach_data(teach_data), .start_position_in(start_position_in),
    .position_select_in(position_select_in), .term_seen(term_seen));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic chk1(input string nm, input logic exp, input logic got);
    check(nm, {31'h0, exp}, {31'h0, got});
  endtask : chk1

  task automatic wait_rdy();
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask : wait_rdy

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= servo_status_pkg::AHB_NONSEQ;
    wait_rdy();
    htrans <= servo_status_pkg::AHB_IDLE;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(nm, exp, rd);
  endtask : rchk

  // Terminals lag a pin by up to eight cycles, so ten leave margin.
  task automatic settle();
    repeat (10) @(posedge hclk);
  endtask : settle

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, fstop, frun, cpu, permit} = 7'h0;
    {haddr, htrans, hwdata, pwr, alarms} = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk1("ready at reset", 1'b0, servo_ready);
    check("code at reset", 32'h0, {27'h0, code});
    chk1("hresp", 1'b0, hresp);
    rchk("ctrl reset", 8'h00, 32'h0);
    rchk("limit reset", 8'h14, 32'h0000ffff);
    rchk("unmapped", 8'h3c, 32'h0);
    foreach (fa[i]) bus(8'h20 + 8'(4 * i), 1'b1, {24'h0, fa[i]});
    for (int k = 0; k < 5; k++) begin
      fstop <= (k != 0);
      frun <= (k == 1);
      cpu <= (k != 2);
      pwr <= (k == 3) ? 3'h6 : 3'h7;
      settle();
      chk1("ready", k == 4, servo_ready);
      chk1("ready term", k == 4, term_seen[0]);
    end
    foreach (et[j]) begin
      bus(8'h00, 1'b1, {29'h0, et[j][3], 1'b0, et[j][1]});
      permit <= et[j][2];
      settle();
      chk1("edit", et[j][0], edit_response);
      chk1("write allow", et[j][0], param_write_allow);
      chk1("edit term", et[j][0], term_seen[1]);
    end
    bus(8'h14, 1'b1, 32'h100);
    foreach (tt[j]) begin
      servo_host_model_inst.teach(tt[j][19:16], tt[j][15:0]);
      settle();
      chk1("data err", tt[j][20], data_error);
      chk1("data term", tt[j][20], term_seen[2]);
    end
    foreach (at[j]) begin
      bus(8'h00, 1'b1, {30'h0, at[j][5], 1'b0});
      servo_host_model_inst.start(at[j][4:1]);
      chk1("addr err", at[j][0], address_error);
      chk1("addr term", at[j][0], term_seen[3]);
    end
    for (int i = 0; i < 5; i++) bus(8'h20 + 8'(4 * i), 1'b1, 32'h20 + i);
    foreach (av[j]) begin
      alarms <= av[j];
      settle();
      check("code", {27'h0, ac[j]}, {27'h0, code});
      check("code term", {27'h0, ac[j]}, {27'h0, term_seen});
      chk1("ready in alarm", 1'b0, servo_ready);
      chk1("alm", 1'b1, alarm_detect);
      alarms <= 28'h0;
      settle();
      bus(8'h00, 1'b1, 32'h8);
      settle();
      check("no code", 32'h0, {27'h0, term_seen});
    end
    bus(8'h0c, 1'b1, 32'hf);
    alarms <= 28'h100;
    settle();
    rchk("irq stat", 8'h0c, 32'h3);
    chk1("irq masked", 1'b0, irq);
    bus(8'h10, 1'b1, 32'h2);
    settle();
    chk1("irq raised", 1'b1, irq);
    alarms <= 28'h0;
    settle();
    bus(8'h00, 1'b1, 32'h8);
    bus(8'h0c, 1'b1, 32'h2);
    settle();
    chk1("irq cleared", 1'b0, irq);
    rchk("irq stat left", 8'h0c, 32'h1);
    end_sim();
  end
endmodule : test_servo_status_out

bind servo_status_out servo_status_out_chk servo_status_out_chk_inst (.hclk(hclk), .hresetn(hresetn),
  .forced_stop_in(forced_stop_in), .free_run_in(free_run_in), .start_position_in(start_position_in),
  .position_select_in(position_select_in), .alarm_in(alarm_in), .teach_strobe(teach_strobe),
  .teach_addr(teach_addr), .servo_ready(servo_ready), .data_error(data_error),
  .address_error(address_error), .alarm_detect(alarm_detect), .alarm_code_bit0(alarm_code_bit0),
  .alarm_code_bit1(alarm_code_bit1), .alarm_code_bit2(alarm_code_bit2),
  .alarm_code_bit3(alarm_code_bit3), .alarm_code_bit4(alarm_code_bit4));

`default_nettype wire
